// ### design/mrss_cfg.svh
`ifndef MRSS_CFG_SVH
`define MRSS_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define MRSS_SPD_W          12
`define MRSS_TIM_W          8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MRSS_CLK_MHZ        200
`define MRSS_NOTICE_MS      2000
`define MRSS_BLINK_MS       250
`define MRSS_BLINK_TOGGLES  4'hc
`define MRSS_STARTUP_CYC    4'h8

// ----------------------------------------------------------------
// speed dial and entry defaults
// ----------------------------------------------------------------
`define MRSS_SPD_MIN        12'h000
`define MRSS_SPD_MAX        12'hfa0
`define MRSS_STEP_SLOW      12'h001
`define MRSS_STEP_FAST      12'h00a
`define MRSS_SPD_RST        12'h000
`define MRSS_TIM_RST        8'h05
`define MRSS_ENTRY_ZERO     2'h0

`endif

// ### design/mrss_pkg.sv
`include "mrss_cfg.svh"

package mrss_pkg;
	typedef enum logic [1:0] {MRSS_SRC_PANEL, MRSS_SRC_EXT_PANEL, MRSS_SRC_EXT_LOCKED} mrss_src_t;
	typedef enum logic [1:0] {MRSS_ST_IDLE, MRSS_ST_RUN, MRSS_ST_REVERSE} mrss_state_t;
	typedef struct packed {
		logic [`MRSS_SPD_W-1:0] speed;
		logic [`MRSS_TIM_W-1:0] accel;
		logic [`MRSS_TIM_W-1:0] decel;
	} mrss_entry_t;
endpackage

// ### design/mrss_entry_if.sv
`timescale 1ns/1ps

interface mrss_entry_if;
	logic [1:0]           rd_idx;
	mrss_pkg::mrss_entry_t rd_entry;
	mrss_pkg::mrss_entry_t zero_entry;
	logic                 wr_en;
	logic [1:0]           wr_idx;
	mrss_pkg::mrss_entry_t wr_entry;
	modport store (input rd_idx, input wr_en, input wr_idx, input wr_entry, output rd_entry, output zero_entry);
	modport user (output rd_idx, output wr_en, output wr_idx, output wr_entry, input rd_entry, input zero_entry);
endinterface

// ### design/mrss_pin_filter.sv
`timescale 1ns/1ps

module mrss_pin_filter #(
	parameter int W = 10
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [W-1:0] lvl_next;

	// ----------------------------------------------------------------
	// three-stage sync, change accepted once stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg  <= pin_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule // mrss_pin_filter

// ### design/mrss_entry_store.sv
`timescale 1ns/1ps
`include "mrss_cfg.svh"

module mrss_entry_store (
	input wire logic     clk_sys,
	input wire logic     rst_n,
	mrss_entry_if.store  bus
);
	import mrss_pkg::*;

	mrss_entry_t entries_reg  [4];
	mrss_entry_t entries_next [4];

	// ----------------------------------------------------------------
	// four operation entries
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			entries_next[i] = entries_reg[i];
		end
		if (bus.wr_en) begin
			entries_next[bus.wr_idx] = bus.wr_entry;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				entries_reg[i] <= '{speed: `MRSS_SPD_RST, accel: `MRSS_TIM_RST, decel: `MRSS_TIM_RST};
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				entries_reg[i] <= entries_next[i];
			end
		end
	end

	assign bus.rd_entry   = entries_reg[bus.rd_idx];
	assign bus.zero_entry = entries_reg[`MRSS_ENTRY_ZERO];
endmodule // mrss_entry_store

// ### design/mrss_run_speed_select.sv
`timescale 1ns/1ps
`include "mrss_cfg.svh"

module mrss_run_speed_select #(
	parameter int unsigned NOTICE_CYC = `MRSS_NOTICE_MS * `MRSS_CLK_MHZ * 1000,
	parameter int unsigned BLINK_CYC  = `MRSS_BLINK_MS * `MRSS_CLK_MHZ * 1000
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   run_switch_pin,
	input  wire logic                   dir_switch_pin,
	input  wire logic                   dial_cw_pin,
	input  wire logic                   dial_ccw_pin,
	input  wire logic                   dial_fast_pin,
	input  wire logic                   dial_press_pin,
	input  wire logic                   forward_run_input,
	input  wire logic                   backward_run_input,
	input  wire logic                   entry_select_low,
	input  wire logic                   entry_select_high,
	input  wire mrss_pkg::mrss_src_t    run_source_param,
	input  wire logic                   lock_enable,
	input  wire logic                   use_pot_ramp,
	input  wire logic [`MRSS_TIM_W-1:0] pot_accel,
	input  wire logic [`MRSS_TIM_W-1:0] pot_decel,
	input  wire logic                   monitor_view,
	input  wire logic                   motor_stopped,
	input  wire logic                   data_wr_en,
	input  wire logic [1:0]             data_wr_idx,
	input  wire mrss_pkg::mrss_entry_t  data_wr_entry,
	output logic                        motor_run,
	output logic                        motor_reverse,
	output logic                        quick_stop,
	output logic [`MRSS_SPD_W-1:0]      speed_cmd,
	output logic [`MRSS_TIM_W-1:0]      accel_cmd,
	output logic [`MRSS_TIM_W-1:0]      decel_cmd,
	output logic [1:0]                  active_entry,
	output logic [`MRSS_SPD_W-1:0]      shown_speed,
	output logic                        display_blink,
	output logic                        confirm_blink,
	output logic                        panel_locked_notice,
	output logic                        powerup_run_block_alarm,
	output logic                        fault_output
);
	import mrss_pkg::*;

	localparam int NW = $clog2(NOTICE_CYC + 1);
	localparam int BW = $clog2(BLINK_CYC + 1);

	function automatic logic [`MRSS_SPD_W-1:0] mrss_step(input logic [`MRSS_SPD_W-1:0] v,
		input logic [`MRSS_SPD_W-1:0] step, input logic up);
		logic [`MRSS_SPD_W:0] s;
		s = {1'b0, v} + {1'b0, step};
		if (up) begin
			mrss_step = (s > {1'b0, `MRSS_SPD_MAX}) ? `MRSS_SPD_MAX : s[`MRSS_SPD_W-1:0];
		end else begin
			mrss_step = ((v - `MRSS_SPD_MIN) < step) ? `MRSS_SPD_MIN : v - step;
		end
	endfunction

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	logic [9:0] filt, prev_reg;
	logic f_run, f_dir, f_cw, f_ccw, f_fast, f_press, f_fwd, f_bwd, f_m0, f_m1;
	logic p_run, p_dir, p_cw, p_ccw, p_fast, p_press, p_fwd, p_bwd, p_m0, p_m1;

	mrss_pin_filter #(.W(10)) u_filter (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.pin_in    ({run_switch_pin, dir_switch_pin, dial_cw_pin, dial_ccw_pin, dial_fast_pin,
		              dial_press_pin, forward_run_input, backward_run_input, entry_select_low,
		              entry_select_high}),
		.level_out (filt)
	);

	assign {f_run, f_dir, f_cw, f_ccw, f_fast, f_press, f_fwd, f_bwd, f_m0, f_m1} = filt;
	assign {p_run, p_dir, p_cw, p_ccw, p_fast, p_press, p_fwd, p_bwd, p_m0, p_m1} = prev_reg;

	logic cw_ev, ccw_ev, press_ev, dir_ev;
	assign cw_ev    = f_cw & ~p_cw;
	assign ccw_ev   = f_ccw & ~p_ccw;
	assign press_ev = f_press & ~p_press;
	assign dir_ev   = f_dir ^ p_dir;

	// ----------------------------------------------------------------
	// entry store
	// ----------------------------------------------------------------
	mrss_entry_if ebus ();

	mrss_entry_store u_store (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bus     (ebus.store)
	);

	// ----------------------------------------------------------------
	// run decision
	// ----------------------------------------------------------------
	logic ext, locked, one_in, qstop, want_run, want_rev, dial_en, run_ok, startup_done;

	assign ext     = run_source_param != MRSS_SRC_PANEL;
	assign locked  = run_source_param == MRSS_SRC_EXT_LOCKED;
	assign one_in  = f_fwd ^ f_bwd;
	assign qstop   = ext & f_fwd & f_bwd;
	assign dial_en = ~locked & ~lock_enable;

	always_comb begin
		case (run_source_param)
			MRSS_SRC_EXT_PANEL: begin
				want_run = f_run & one_in;
				want_rev = f_dir ^ f_bwd;
			end
			MRSS_SRC_EXT_LOCKED: begin
				want_run = one_in;
				want_rev = f_bwd;
			end
			default: begin
				want_run = f_run;
				want_rev = f_dir;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// power-up check and motion control
	// ----------------------------------------------------------------
	logic [3:0]  start_cnt_reg, start_cnt_next;
	logic        alarm_reg, alarm_next;
	mrss_state_t state_reg, state_next;
	logic        dir_reg, dir_next;

	// sampling waits for the filter to settle so a bouncing switch cannot slip through
	assign startup_done = start_cnt_reg == `MRSS_STARTUP_CYC;
	assign run_ok       = startup_done & ~alarm_reg;

	always_comb begin
		start_cnt_next = startup_done ? start_cnt_reg : start_cnt_reg + 4'h1;
		alarm_next     = alarm_reg;
		if (start_cnt_reg == `MRSS_STARTUP_CYC - 4'h1 && f_run) begin
			alarm_next = 1'b1;
		end
		state_next = state_reg;
		dir_next   = dir_reg;
		case (state_reg)
			MRSS_ST_IDLE: begin
				if (run_ok && want_run && !qstop) begin
					state_next = MRSS_ST_RUN;
					dir_next   = want_rev;
				end
			end
			MRSS_ST_RUN: begin
				if (!run_ok || !want_run || qstop) begin
					state_next = MRSS_ST_IDLE;
				end else if (want_rev != dir_reg) begin
					state_next = MRSS_ST_REVERSE;
				end
			end
			MRSS_ST_REVERSE: begin
				if (!run_ok || !want_run || qstop) begin
					state_next = MRSS_ST_IDLE;
				end else if (motor_stopped) begin
					state_next = MRSS_ST_RUN;
					dir_next   = want_rev;
				end
			end
			default: state_next = MRSS_ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// dial, commit and confirmation
	// ----------------------------------------------------------------
	logic [`MRSS_SPD_W-1:0] adj_reg, adj_next, step;
	logic                   pend_reg, pend_next, commit;
	logic [3:0]             flash_reg, flash_next;
	logic [BW-1:0]          blink_cnt_reg, blink_cnt_next;
	logic                   phase_reg, phase_next, tick;

	assign step = f_fast ? `MRSS_STEP_FAST : `MRSS_STEP_SLOW;
	assign tick = blink_cnt_reg == BW'(BLINK_CYC - 1);

	always_comb begin
		adj_next  = adj_reg;
		pend_next = pend_reg;
		commit    = 1'b0;
		if (!pend_reg) begin
			adj_next = ebus.zero_entry.speed;
		end
		if (state_reg == MRSS_ST_RUN && state_next == MRSS_ST_IDLE) begin
			pend_next = 1'b0;
			adj_next  = ebus.zero_entry.speed;
		end
		if (dial_en && press_ev && pend_reg) begin
			commit    = 1'b1;
			pend_next = 1'b0;
		end
		// a step landing in the commit cycle stays pending, so it is not lost
		if (dial_en && cw_ev) begin
			adj_next  = mrss_step(adj_reg, step, 1'b1);
			pend_next = 1'b1;
		end else if (dial_en && ccw_ev) begin
			adj_next  = mrss_step(adj_reg, step, 1'b0);
			pend_next = 1'b1;
		end
		blink_cnt_next = tick ? '0 : blink_cnt_reg + BW'(1);
		phase_next     = tick ? ~phase_reg : phase_reg;
		flash_next     = (tick && flash_reg != 4'h0) ? flash_reg - 4'h1 : flash_reg;
		if (!locked && press_ev && !pend_reg && state_reg == MRSS_ST_IDLE) begin
			flash_next = `MRSS_BLINK_TOGGLES;
		end
	end

	always_comb begin
		ebus.wr_en    = commit | data_wr_en;
		ebus.wr_idx   = commit ? `MRSS_ENTRY_ZERO : data_wr_idx;
		ebus.wr_entry = data_wr_entry;
		if (commit) begin
			ebus.wr_entry = '{speed: adj_reg, accel: ebus.zero_entry.accel, decel: ebus.zero_entry.decel};
		end
		ebus.rd_idx = ext ? {f_m1, f_m0} : `MRSS_ENTRY_ZERO;
	end

	// ----------------------------------------------------------------
	// lock-out notice
	// ----------------------------------------------------------------
	logic [NW-1:0] notice_cnt_reg, notice_cnt_next;
	logic          notice_load;

	assign notice_load = startup_done & locked & (dir_ev | ((cw_ev | ccw_ev | press_ev) & monitor_view));

	always_comb begin
		notice_cnt_next = (notice_cnt_reg != '0) ? notice_cnt_reg - NW'(1) : notice_cnt_reg;
		if (notice_load) begin
			notice_cnt_next = NW'(NOTICE_CYC);
		end
	end

	// ----------------------------------------------------------------
	// output staging
	// ----------------------------------------------------------------
	logic                   run_next, qstop_next, notice_next;
	logic [`MRSS_SPD_W-1:0] speed_next;
	logic [`MRSS_TIM_W-1:0] accel_next, decel_next;

	always_comb begin
		run_next    = state_next == MRSS_ST_RUN;
		qstop_next  = qstop;
		speed_next  = (ebus.rd_idx == `MRSS_ENTRY_ZERO && pend_reg) ? adj_reg : ebus.rd_entry.speed;
		accel_next  = use_pot_ramp ? pot_accel : ebus.rd_entry.accel;
		decel_next  = use_pot_ramp ? pot_decel : ebus.rd_entry.decel;
		notice_next = locked & (f_run | notice_cnt_next != '0);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prev_reg                <= '0;
			start_cnt_reg           <= 4'h0;
			alarm_reg               <= 1'b0;
			state_reg               <= MRSS_ST_IDLE;
			dir_reg                 <= 1'b0;
			adj_reg                 <= `MRSS_SPD_RST;
			pend_reg                <= 1'b0;
			flash_reg               <= 4'h0;
			blink_cnt_reg           <= '0;
			phase_reg               <= 1'b0;
			notice_cnt_reg          <= '0;
			motor_run               <= 1'b0;
			motor_reverse           <= 1'b0;
			quick_stop              <= 1'b0;
			speed_cmd               <= `MRSS_SPD_RST;
			accel_cmd               <= `MRSS_TIM_RST;
			decel_cmd               <= `MRSS_TIM_RST;
			active_entry            <= `MRSS_ENTRY_ZERO;
			display_blink           <= 1'b0;
			confirm_blink           <= 1'b0;
			panel_locked_notice     <= 1'b0;
			powerup_run_block_alarm <= 1'b0;
			fault_output            <= 1'b1;
		end else begin
			prev_reg                <= filt;
			start_cnt_reg           <= start_cnt_next;
			alarm_reg               <= alarm_next;
			state_reg               <= state_next;
			dir_reg                 <= dir_next;
			adj_reg                 <= adj_next;
			pend_reg                <= pend_next;
			flash_reg               <= flash_next;
			blink_cnt_reg           <= blink_cnt_next;
			phase_reg               <= phase_next;
			notice_cnt_reg          <= notice_cnt_next;
			motor_run               <= run_next;
			motor_reverse           <= dir_next;
			quick_stop              <= qstop_next;
			speed_cmd               <= speed_next;
			accel_cmd               <= accel_next;
			decel_cmd               <= decel_next;
			active_entry            <= ebus.rd_idx;
			display_blink           <= pend_next & phase_next;
			confirm_blink           <= (flash_next != 4'h0) & phase_next;
			panel_locked_notice     <= notice_next;
			powerup_run_block_alarm <= alarm_next;
			fault_output            <= ~alarm_next;
		end
	end

	assign shown_speed = adj_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_ALARM_BLOCKS: assert property (powerup_run_block_alarm |-> !motor_run)
		else $error("motor driven under power-up alarm");
	AST_FAULT_OFF: assert property ($rose(alarm_reg) |-> !fault_output ##1 !fault_output)
		else $error("fault output conducting under alarm");
	AST_STANDBY_STOP: assert property ((!locked && !f_run) |=> !motor_run)
		else $error("motor kept running with switch at standby");
	AST_DIAL_UP: assert property ((dial_en && cw_ev && !f_fast && adj_reg < `MRSS_SPD_MAX)
		|=> adj_reg == $past(adj_reg) + `MRSS_STEP_SLOW)
		else $error("slow dial step did not add one");
	AST_COMMIT: assert property ((dial_en && press_ev && pend_reg && !cw_ev && !ccw_ev)
		|=> !pend_reg ##1 !display_blink)
		else $error("dial press did not commit speed");
	AST_STEP_PEND: assert property ((dial_en && (cw_ev || ccw_ev)) |=> pend_reg)
		else $error("dial step lost its pending mark");
	AST_LOCK: assert property (!dial_en |=> !$rose(pend_reg))
		else $error("dial changed speed while locked");
	AST_BOTH_INPUTS: assert property ((ext && f_fwd && f_bwd) |=> quick_stop && !motor_run)
		else $error("both run inputs did not stop immediately");
	AST_ENTRY_SEL: assert property (ext |=> active_entry[1] == $past(f_m1) && active_entry[0] == $past(f_m0))
		else $error("wrong operation entry selected");
	AST_NOTICE_RUN: assert property ((locked && f_run) |=> panel_locked_notice)
		else $error("lock-out notice missing with switch at run");
	AST_REV_WAIT: assert property ((state_reg == MRSS_ST_REVERSE && !motor_stopped) |=> !motor_run)
		else $error("reversal restarted before stop");
	AST_POT_RAMP: assert property (use_pot_ramp |=> accel_cmd == $past(pot_accel))
		else $error("ramp time not taken from potentiometer");

	COV_REVERSE: cover property (state_reg == MRSS_ST_REVERSE ##[1:1000] motor_run);
	COV_COMMIT: cover property (commit);
	COV_NOTICE: cover property ($rose(panel_locked_notice));
endmodule // mrss_run_speed_select

// ### tb/mrss_ctl_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// controller driving the run and select inputs, plus motor feedback
// ----------------------------------------------------------------
module mrss_ctl_model (
	input  wire logic clk_sys,
	input  wire logic motor_run,
	output logic      forward_run_input,
	output logic      backward_run_input,
	output logic      entry_select_low,
	output logic      entry_select_high,
	output logic      motor_stopped
);
	logic [3:0] stop_cnt_reg = 4'h8;

	initial begin
		forward_run_input  = 1'b0;
		backward_run_input = 1'b0;
		entry_select_low   = 1'b0;
		entry_select_high  = 1'b0;
	end

	// changes land on falling edges, away from the sampling edge
	task drive(input logic f, input logic b, input logic [1:0] idx);
		@(negedge clk_sys);
		forward_run_input  = f;
		backward_run_input = b;
		{entry_select_high, entry_select_low} = idx;
	endtask

	// the motor coasts for a while, so a reversal really has to wait
	always @(posedge clk_sys) begin
		stop_cnt_reg <= motor_run ? 4'h0 : ((stop_cnt_reg == 4'h8) ? 4'h8 : stop_cnt_reg + 4'h1);
	end
	assign motor_stopped = (stop_cnt_reg == 4'h8);
endmodule // mrss_ctl_model

// ### tb/motor_run_speed_select_test.sv
`timescale 1ns/1ps

`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("Error %0t: got %h want %h", $time, a, b); \
	end \
end
`define WAITH(s) for (k = 0; k < 40 && (s) !== 1'b1; k++) @(negedge clk_sys);

module motor_run_speed_select_test;
	import mrss_pkg::*;
	typedef struct packed {
		logic [1:0]  sel;
		logic [11:0] spd;
		logic [7:0]  acc;
	} mrss_row_t;
	mrss_row_t   rows [4] = '{'{2'h0, 12'h123, 8'h10}, '{2'h1, 12'h3e8, 8'h11},
		'{2'h2, 12'h7d0, 8'h12}, '{2'h3, 12'h1f4, 8'h13}};
	logic        clk_sys, rst_n, run_switch_pin, dir_switch_pin, dial_cw_pin, dial_ccw_pin;
	logic        dial_fast_pin, dial_press_pin, lock_enable, use_pot_ramp, monitor_view, data_wr_en;
	logic        forward_run_input, backward_run_input, entry_select_low, entry_select_high, motor_stopped;
	logic        motor_run, motor_reverse, quick_stop, display_blink, confirm_blink;
	logic        panel_locked_notice, powerup_run_block_alarm, fault_output;
	logic [1:0]  data_wr_idx, active_entry;
	logic [7:0]  pot_accel, pot_decel, accel_cmd, decel_cmd;
	logic [11:0] speed_cmd, shown_speed, spd;
	mrss_src_t   run_source_param;
	mrss_entry_t data_wr_entry;
	int          n_errors, samples_checked, k, cycles;

	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	mrss_run_speed_select #(.NOTICE_CYC(50), .BLINK_CYC(8)) dut (
		.clk_sys, .rst_n, .run_switch_pin, .dir_switch_pin, .dial_cw_pin, .dial_ccw_pin, .dial_fast_pin,
		.dial_press_pin, .forward_run_input, .backward_run_input, .entry_select_low, .entry_select_high,
		.run_source_param, .lock_enable, .use_pot_ramp, .pot_accel, .pot_decel, .monitor_view,
		.motor_stopped, .data_wr_en, .data_wr_idx, .data_wr_entry, .motor_run, .motor_reverse,
		.quick_stop, .speed_cmd, .accel_cmd, .decel_cmd, .active_entry, .shown_speed, .display_blink,
		.confirm_blink, .panel_locked_notice, .powerup_run_block_alarm, .fault_output);
	mrss_ctl_model ctl (.clk_sys, .motor_run, .forward_run_input, .backward_run_input,
		.entry_select_low, .entry_select_high, .motor_stopped);

	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	task tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// filter needs highs and gaps of at least two cycles
	task step(input logic [2:0] d);
		{dial_cw_pin, dial_ccw_pin, dial_press_pin} = d;
		tick(4);
		{dial_cw_pin, dial_ccw_pin, dial_press_pin} = 3'h0;
		tick(8);
	endtask

	task print_verdict();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{dir_switch_pin, dial_cw_pin, dial_ccw_pin, dial_fast_pin, dial_press_pin} = 5'h00;
		{lock_enable, use_pot_ramp, monitor_view, data_wr_en, data_wr_idx} = 6'h00;
		pot_accel = 8'h33;
		pot_decel = 8'h44;
		data_wr_entry = '0;
		run_source_param = MRSS_SRC_PANEL;
		rst_n = 1'b0;
		run_switch_pin = 1'b1;
		tick(3);
		rst_n = 1'b1;
		tick(20);
		`CHK(powerup_run_block_alarm, 1'b1)
		`CHK(fault_output, 1'b0)
		`CHK(motor_run, 1'b0)
		rst_n = 1'b0;
		run_switch_pin = 1'b0;
		tick(3);
		`CHK(fault_output, 1'b1)
		`CHK(accel_cmd, 8'h05)
		`CHK(powerup_run_block_alarm, 1'b0)
		rst_n = 1'b1;
		tick(20);
		run_source_param = MRSS_SRC_EXT_PANEL;
		run_switch_pin = 1'b1;
		ctl.drive(1'b1, 1'b0, 2'h0);
		tick(8);
		`CHK(motor_run, 1'b1)
		`CHK(motor_reverse, 1'b0)
		foreach (rows[i]) begin
			data_wr_en = 1'b1;
			data_wr_idx = rows[i].sel;
			data_wr_entry = '{rows[i].spd, rows[i].acc, rows[i].acc + 8'h10};
			tick(1);
			data_wr_en = 1'b0;
			ctl.drive(1'b1, 1'b0, rows[i].sel);
			tick(8);
			`CHK(active_entry, rows[i].sel)
			`CHK(speed_cmd, rows[i].spd)
			`CHK(accel_cmd, rows[i].acc)
			`CHK(decel_cmd, rows[i].acc + 8'h10)
		end
		use_pot_ramp = 1'b1;
		tick(8);
		`CHK(accel_cmd, 8'h33)
		`CHK(decel_cmd, 8'h44)
		use_pot_ramp = 1'b0;
		ctl.drive(1'b0, 1'b0, 2'h0);
		tick(8);
		`CHK(motor_run, 1'b0)
		ctl.drive(1'b0, 1'b1, 2'h0);
		tick(8);
		`CHK(motor_run, 1'b1)
		`CHK(motor_reverse, 1'b1)
		ctl.drive(1'b1, 1'b1, 2'h0);
		tick(8);
		`CHK(quick_stop, 1'b1)
		`CHK(motor_run, 1'b0)
		ctl.drive(1'b1, 1'b0, 2'h0);
		tick(8);
		`CHK(quick_stop, 1'b0)
		`CHK(motor_run, 1'b1)
		dir_switch_pin = 1'b1;
		tick(7);
		`CHK(motor_run, 1'b0)
		`WAITH(motor_run)
		`CHK(motor_run, 1'b1)
		`CHK(motor_reverse, 1'b1)
		run_switch_pin = 1'b0;
		tick(8);
		`CHK(motor_run, 1'b0)
		run_source_param = MRSS_SRC_PANEL;
		ctl.drive(1'b0, 1'b0, 2'h0);
		dir_switch_pin = 1'b0;
		tick(12);
		run_switch_pin = 1'b1;
		tick(8);
		`CHK(motor_run, 1'b1)
		`CHK(speed_cmd, rows[0].spd)
		spd = rows[0].spd;
		step(3'h4);
		`CHK(shown_speed, spd + 12'h001)
		dial_fast_pin = 1'b1;
		step(3'h4);
		`CHK(shown_speed, spd + 12'h00b)
		dial_fast_pin = 1'b0;
		step(3'h2);
		`CHK(shown_speed, spd + 12'h00a)
		`WAITH(display_blink)
		`CHK(display_blink, 1'b1)
		step(3'h1);
		tick(20);
		`CHK(display_blink, 1'b0)
		lock_enable = 1'b1;
		step(3'h4);
		`CHK(shown_speed, spd + 12'h00a)
		lock_enable = 1'b0;
		run_switch_pin = 1'b0;
		tick(12);
		run_switch_pin = 1'b1;
		tick(8);
		`CHK(speed_cmd, spd + 12'h00a)
		run_switch_pin = 1'b0;
		tick(20);
		step(3'h1);
		`WAITH(confirm_blink)
		`CHK(confirm_blink, 1'b1)
		`CHK(shown_speed, spd + 12'h00a)
		// locked panel: notice timing and ignored controls
		run_source_param = MRSS_SRC_EXT_LOCKED;
		monitor_view = 1'b1;
		tick(4);
		dir_switch_pin = 1'b1;
		tick(8);
		`CHK(panel_locked_notice, 1'b1)
		tick(60);
		`CHK(panel_locked_notice, 1'b0)
		step(3'h4);
		`CHK(panel_locked_notice, 1'b1)
		`CHK(shown_speed, spd + 12'h00a)
		run_switch_pin = 1'b1;
		tick(70);
		`CHK(panel_locked_notice, 1'b1)
		`CHK(motor_run, 1'b0)
		ctl.drive(1'b1, 1'b0, 2'h0);
		tick(8);
		`CHK(motor_run, 1'b1)
		`CHK(motor_reverse, 1'b0)
		print_verdict();
	end
endmodule // motor_run_speed_select_test
